// file: verilog/rls_sequencer.sv
// Return and counter-loop sequencer: decodes return and loop setup opcodes and runs the stacks.
`timescale 1ns/100ps
`include "rls_defs.svh"

module rls_sequencer #(
  parameter int PC_STACK_DEPTH = 30,
  parameter int LOOP_STACK_DEPTH = 6,
  parameter logic [`RLS_IRQ_W-1:0] STATUS_PUSH_MASK = 32'h0000003c
) (
  // Clock and reset.
  input wire logic clk_in,
  input wire logic sys_rst_in,
  // Instruction stream.
  input wire logic instr_valid_in,
  input wire logic [`RLS_INSTR_W-1:0] instr_in,
  input wire logic [`RLS_ADDR_W-1:0] instr_pc_in,
  // Condition results and mode.
  input wire logic condition_field_x_in,
  input wire logic condition_field_y_in,
  input wire logic simd_mode_in,
  input wire logic abs_end_addr_in,
  input wire logic [`RLS_UREG_DATA_W-1:0] ureg_data_in,
  // Other sequencer events.
  input wire logic call_push_in,
  input wire logic [`RLS_ADDR_W-1:0] call_addr_in,
  input wire logic loop_dec_in,
  input wire logic loop_exit_in,
  input wire logic [`RLS_IRQ_W-1:0] irq_latch_set_in,
  input wire logic [`RLS_IRQ_W-1:0] irq_mask_ptr_set_in,
  // Branch results.
  output logic branch_take_out,
  output logic [`RLS_ADDR_W-1:0] branch_addr_out,
  output logic branch_delayed_out,
  output logic status_pop_out,
  // Compute enables.
  output logic compute_x_en_out,
  output logic compute_y_en_out,
  output logic [`RLS_COMP_W-1:0] compute_word_out,
  output logic compute_cplx_regs_out,
  // Interrupt bookkeeping.
  output logic [`RLS_IRQ_W-1:0] irq_latch_out,
  output logic [`RLS_IRQ_W-1:0] irq_mask_pointer_out,
  // Loop state.
  output logic [`RLS_CNT_W-1:0] current_loop_count_out,
  output logic loop_count_expired_out,
  output logic [`RLS_ADDR_W-1:0] pc_stack_top_out,
  output logic [`RLS_ADDR_W+`RLS_TERM_W-1:0] loop_end_top_out
);

  // Splits a raw opcode into its fields and classifies it.
  function automatic rls_pkg::rls_dec_t rls_decode(input logic [`RLS_INSTR_W-1:0] w);
    rls_pkg::rls_dec_t d;
    d = '0;
    d.op = rls_pkg::RLS_OP_NONE;
    if (w[`RLS_TOP_HI:`RLS_TOP_LO] == `RLS_TOP_VAL)
    begin
      if (w[`RLS_GRP_HI:`RLS_GRP_LO] == `RLS_GRP_RET)
      begin
        d.op = w[`RLS_KIND_BIT] ? rls_pkg::RLS_OP_RTI : rls_pkg::RLS_OP_RTS;
      end
      else if (w[`RLS_GRP_HI:`RLS_GRP_LO] == `RLS_GRP_LOOP)
      begin
        d.op = rls_pkg::RLS_OP_LOOP;
      end
    end
    d.condition_field_omit = (w[`RLS_CONDITION_FIELD_HI:`RLS_CONDITION_FIELD_LO] == `RLS_CONDITION_FIELD_TRUE);
    d.delay = w[`RLS_J_BIT];
    d.els = w[`RLS_E_BIT];
    d.lr = w[`RLS_LR_BIT] && !w[`RLS_KIND_BIT];
    d.comp = w[`RLS_COMP_HI:`RLS_COMP_LO];
    d.comp_nop = (d.comp == `RLS_COMP_NOP);
    d.ureg_src = w[`RLS_KIND_BIT];
    d.imm_cnt = w[`RLS_DATA_HI:`RLS_DATA_LO];
    d.rel = w[`RLS_REL_HI:`RLS_REL_LO];
    return d;
  endfunction : rls_decode

  // Isolates the lowest set bit, which is the highest-priority interrupt in service.
  function automatic logic [`RLS_IRQ_W-1:0] rls_lowest_bit(input logic [`RLS_IRQ_W-1:0] v);
    return v & ((~v) + {{(`RLS_IRQ_W-1){1'b0}}, 1'b1});
  endfunction : rls_lowest_bit

  rls_pkg::rls_state_t st_r;
  rls_pkg::rls_state_t st_nxt;
  rls_pkg::rls_dec_t dec;

  logic is_ret;
  logic is_rti;
  logic is_loop;
  logic elem_x;
  logic elem_y;
  logic ret_take;
  logic [`RLS_IRQ_W-1:0] irq_clr;
  logic [`RLS_CNT_W-1:0] load_cnt;
  logic [`RLS_ADDR_W-1:0] loop_end;
  logic [`RLS_ADDR_W-1:0] pc_top;
  logic [`RLS_CNT_W-1:0] cnt_top;
  logic [`RLS_ADDR_W+`RLS_TERM_W-1:0] lend_top;
  logic pc_push;
  logic pc_pop;
  logic [`RLS_ADDR_W-1:0] pc_push_data;

  // Decode the incoming word; nothing acts unless the word is marked valid.
  always_comb
  begin
    dec = rls_decode(instr_in);
    is_ret = instr_valid_in && ((dec.op == rls_pkg::RLS_OP_RTS) || (dec.op == rls_pkg::RLS_OP_RTI));
    is_rti = instr_valid_in && (dec.op == rls_pkg::RLS_OP_RTI);
    is_loop = instr_valid_in && (dec.op == rls_pkg::RLS_OP_LOOP);
  end

  // Per-element condition; an omitted condition is true in every element.
  assign elem_x = dec.condition_field_omit || condition_field_x_in;
  assign elem_y = dec.condition_field_omit || condition_field_y_in;

  // Dual mode needs both elements true; an else clause without a condition can never run.
  assign ret_take = is_ret && elem_x && (!simd_mode_in || elem_y);

  // Serviced interrupt is cleared only by a taken interrupt return.
  assign irq_clr = (is_rti && ret_take) ? rls_lowest_bit(st_r.mptr) : `RLS_IRQ_ZERO;

  // Loop count source and loop end address.
  assign load_cnt = dec.ureg_src ? ureg_data_in[`RLS_CNT_W-1:0] : dec.imm_cnt;
  assign loop_end = abs_end_addr_in ? dec.rel : (instr_pc_in + dec.rel);

  // PC stack traffic: loop setup pushes the loop start, and a call push in the same cycle is dropped.
  always_comb
  begin
    pc_push = is_loop || call_push_in;
    pc_push_data = is_loop ? (instr_pc_in + `RLS_PC_STEP) : call_addr_in;
    pc_pop = ret_take || loop_exit_in;
  end

  // Next-state logic for every registered output and internal flag.
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.take = ret_take;
    st_nxt.delayed = ret_take && dec.delay;
    st_nxt.status_pop = 1'b0;
    st_nxt.comp_x = 1'b0;
    st_nxt.comp_y = 1'b0;
    st_nxt.comp_word = `RLS_COMP_NOP;
    st_nxt.cplx = 1'b0;
    st_nxt.restore = loop_exit_in;
    if (ret_take)
    begin
      st_nxt.baddr = pc_top;
    end
    if (is_ret)
    begin
      // A plain compute follows the condition, an else compute its inverse, per element.
      st_nxt.comp_x = !dec.comp_nop && (dec.els ? !elem_x : elem_x);
      st_nxt.comp_y = simd_mode_in && !dec.comp_nop && (dec.els ? !elem_y : elem_y);
      st_nxt.comp_word = dec.comp;
      st_nxt.cplx = simd_mode_in;
    end
    // Status pops only when entry to this interrupt pushed it; a subroutine return never does.
    st_nxt.status_pop = |(irq_clr & STATUS_PUSH_MASK);
    // New sets win over a clear of the same bit in the same cycle.
    st_nxt.latch = (st_r.latch & ~irq_clr) | irq_latch_set_in;
    st_nxt.mptr = (st_r.mptr & ~irq_clr) | irq_mask_ptr_set_in;
    // Loop counter: setup loads, exit restores the outer loop's setup count, the decrement event counts down.
    if (is_loop)
    begin
      st_nxt.cnt = load_cnt;
      st_nxt.expired = (load_cnt == `RLS_CNT_ZERO);
      st_nxt.suppress = 1'b0;
    end
    else if (st_r.restore)
    begin
      st_nxt.cnt = cnt_top;
      st_nxt.expired = (cnt_top == `RLS_CNT_ZERO);
    end
    else if (loop_dec_in)
    begin
      if (st_r.suppress)
      begin
        st_nxt.suppress = 1'b0;
      end
      else if (st_r.cnt != `RLS_CNT_ZERO)
      begin
        st_nxt.cnt = st_r.cnt - `RLS_CNT_ONE;
        st_nxt.expired = (st_r.cnt == `RLS_CNT_ONE);
      end
    end
    // The reentry return arms suppression of the decrement on the way back into the loop.
    if (ret_take && dec.lr)
    begin
      st_nxt.suppress = 1'b1;
    end
  end

  // State register.
  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in)
    begin
      st_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // Program counter stack.
  rls_stack #(
    .WIDTH(`RLS_ADDR_W),
    .DEPTH(PC_STACK_DEPTH)
  ) u_pc_stack (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .push_in(pc_push),
    .pop_in(pc_pop),
    .push_data_in(pc_push_data),
    .top_out(pc_top),
    .empty_out(),
    .full_out()
  );

  // Loop address stack holding end address and termination code.
  rls_stack #(
    .WIDTH(`RLS_ADDR_W + `RLS_TERM_W),
    .DEPTH(LOOP_STACK_DEPTH)
  ) u_loop_addr_stack (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .push_in(is_loop),
    .pop_in(loop_exit_in),
    .push_data_in({loop_end, `RLS_TERM_LCE}),
    .top_out(lend_top),
    .empty_out(),
    .full_out()
  );

  // Loop counter stack; after an exit its top is the count the outer loop was set up with.
  rls_stack #(
    .WIDTH(`RLS_CNT_W),
    .DEPTH(LOOP_STACK_DEPTH)
  ) u_loop_cnt_stack (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .push_in(is_loop),
    .pop_in(loop_exit_in),
    .push_data_in(load_cnt),
    .top_out(cnt_top),
    .empty_out(),
    .full_out()
  );

  // Outputs come straight from the state register or the stack top registers.
  assign branch_take_out = st_r.take;
  assign branch_addr_out = st_r.baddr;
  assign branch_delayed_out = st_r.delayed;
  assign status_pop_out = st_r.status_pop;
  assign compute_x_en_out = st_r.comp_x;
  assign compute_y_en_out = st_r.comp_y;
  assign compute_word_out = st_r.comp_word;
  assign compute_cplx_regs_out = st_r.cplx;
  assign irq_latch_out = st_r.latch;
  assign irq_mask_pointer_out = st_r.mptr;
  assign current_loop_count_out = st_r.cnt;
  assign loop_count_expired_out = st_r.expired;
  assign pc_stack_top_out = pc_top;
  assign loop_end_top_out = lend_top;

  // Return address is the PC stack top seen when the return was decoded.
  property p_ret_addr;
    @(posedge clk_in) disable iff (sys_rst_in)
    ret_take |=> (branch_addr_out == $past(pc_top)) && branch_take_out;
  endproperty
  a_ret_addr: assert property (p_ret_addr) else $error("return address not taken from PC stack");

  // A subroutine return never pops status.
  property p_rts_no_status;
    @(posedge clk_in) disable iff (sys_rst_in)
    (ret_take && !is_rti) |=> !status_pop_out;
  endproperty
  a_rts_no_status: assert property (p_rts_no_status) else $error("subroutine return popped status");

  // Interrupt return of a status-pushing interrupt pops status.
  property p_rti_status;
    @(posedge clk_in) disable iff (sys_rst_in)
    (is_rti && ret_take && |(rls_lowest_bit(st_r.mptr) & STATUS_PUSH_MASK)) |=> status_pop_out;
  endproperty
  a_rti_status: assert property (p_rti_status) else $error("interrupt return did not pop status");

  // Serviced bit is clear in both registers after the return unless set again.
  property p_rti_clear;
    @(posedge clk_in) disable iff (sys_rst_in)
    (is_rti && ret_take && (irq_latch_set_in == `RLS_IRQ_ZERO) && (irq_mask_ptr_set_in == `RLS_IRQ_ZERO))
      |=> ((irq_latch_out | irq_mask_pointer_out) & $past(irq_clr)) == `RLS_IRQ_ZERO;
  endproperty
  a_rti_clear: assert property (p_rti_clear) else $error("serviced interrupt bit not cleared");

  // An omitted condition always takes the return.
  property p_uncond_take;
    @(posedge clk_in) disable iff (sys_rst_in)
    (is_ret && dec.condition_field_omit) |=> branch_take_out;
  endproperty
  a_uncond_take: assert property (p_uncond_take) else $error("unconditional return not taken");

  // Plain compute runs when the element condition holds; the pulse ends unless a new return follows.
  property p_plain_comp;
    @(posedge clk_in) disable iff (sys_rst_in)
    (is_ret && !dec.els && !dec.comp_nop && condition_field_x_in) |=> compute_x_en_out ##1 (!compute_x_en_out || $past(is_ret));
  endproperty
  a_plain_comp: assert property (p_plain_comp) else $error("plain compute not enabled");

  // Else compute is blocked while the condition is true.
  property p_else_comp;
    @(posedge clk_in) disable iff (sys_rst_in)
    (is_ret && dec.els && condition_field_x_in) |=> !compute_x_en_out;
  endproperty
  a_else_comp: assert property (p_else_comp) else $error("else compute ran on true condition");

  // Dual mode needs both conditions for the return.
  property p_simd_and;
    @(posedge clk_in) disable iff (sys_rst_in)
    (is_ret && simd_mode_in && !dec.condition_field_omit && !(condition_field_x_in && condition_field_y_in)) |=> !branch_take_out;
  endproperty
  a_simd_and: assert property (p_simd_and) else $error("dual mode return taken on one condition");

  // Delay flag follows the opcode bit of a taken return.
  property p_delay;
    @(posedge clk_in) disable iff (sys_rst_in)
    ret_take |=> branch_delayed_out == $past(dec.delay);
  endproperty
  a_delay: assert property (p_delay) else $error("delay flag mismatch");

  // The decrement after a reentry return leaves the count unchanged.
  property p_suppress;
    @(posedge clk_in) disable iff (sys_rst_in)
    (st_r.suppress && loop_dec_in && !is_loop && !st_r.restore) |=> $stable(current_loop_count_out);
  endproperty
  a_suppress: assert property (p_suppress) else $error("loop count decremented twice");

  // Loop setup loads the count and pushes the end address with the expiry code.
  property p_loop_setup;
    @(posedge clk_in) disable iff (sys_rst_in)
    (is_loop && !loop_exit_in) |=> (current_loop_count_out == $past(load_cnt))
      && (loop_end_top_out == {$past(loop_end), `RLS_TERM_LCE});
  endproperty
  a_loop_setup: assert property (p_loop_setup) else $error("loop setup not loaded");

  // Main scenarios.
  c_rti_taken: cover property (@(posedge clk_in) disable iff (sys_rst_in) is_rti && ret_take);
  c_else_simd: cover property (@(posedge clk_in) disable iff (sys_rst_in) is_ret && simd_mode_in && dec.els);
  c_loop_expire: cover property (@(posedge clk_in) disable iff (sys_rst_in) $rose(loop_count_expired_out));
  c_lr_return: cover property (@(posedge clk_in) disable iff (sys_rst_in) ret_take && dec.lr);

endmodule : rls_sequencer

// file: verilog/rls_defs.svh
// Opcode field positions, encodings and fixed widths of the return and loop sequencer.
`ifndef RLS_DEFS_SVH
`define RLS_DEFS_SVH

// Data path widths.
`define RLS_INSTR_W 48
`define RLS_ADDR_W 24
`define RLS_CNT_W 16
`define RLS_IRQ_W 32
`define RLS_CONDITION_FIELD_W 5
`define RLS_TERM_W 5
`define RLS_COMP_W 23
`define RLS_UREG_DATA_W 32

// Top opcode bits and group codes.
`define RLS_TOP_HI 47
`define RLS_TOP_LO 45
`define RLS_TOP_VAL 3'h0
`define RLS_GRP_HI 44
`define RLS_GRP_LO 41
`define RLS_GRP_RET 4'h5
`define RLS_GRP_LOOP 4'h6
`define RLS_KIND_BIT 40

// Return opcode fields.
`define RLS_CONDITION_FIELD_HI 37
`define RLS_CONDITION_FIELD_LO 33
`define RLS_CONDITION_FIELD_TRUE 5'h1f
`define RLS_J_BIT 26
`define RLS_E_BIT 25
`define RLS_LR_BIT 24
`define RLS_COMP_HI 22
`define RLS_COMP_LO 0
`define RLS_COMP_NOP 23'h000000

// Loop setup opcode fields.
`define RLS_DATA_HI 39
`define RLS_DATA_LO 24
`define RLS_REL_HI 23
`define RLS_REL_LO 0
`define RLS_TERM_LCE 5'h0f

// Reset values and address step.
`define RLS_PC_STEP 24'h000001
`define RLS_ADDR_ZERO 24'h000000
`define RLS_CNT_ZERO 16'h0000
`define RLS_CNT_ONE 16'h0001
`define RLS_IRQ_ZERO 32'h00000000

`endif

// file: verilog/rls_pkg.sv
// Types shared by the return and loop sequencer files.
`include "rls_defs.svh"

package rls_pkg;

  // Instruction kinds that this block acts on.
  typedef enum logic [1:0] {
    RLS_OP_NONE,
    RLS_OP_RTS,
    RLS_OP_RTI,
    RLS_OP_LOOP
  } rls_op_t;

  // Decoded opcode fields.
  typedef struct packed {
    rls_op_t op;
    logic condition_field_omit;
    logic delay;
    logic els;
    logic lr;
    logic comp_nop;
    logic [`RLS_COMP_W-1:0] comp;
    logic ureg_src;
    logic [`RLS_CNT_W-1:0] imm_cnt;
    logic [`RLS_ADDR_W-1:0] rel;
  } rls_dec_t;

  // Complete registered state of the sequencer.
  typedef struct packed {
    logic take;
    logic [`RLS_ADDR_W-1:0] baddr;
    logic delayed;
    logic status_pop;
    logic comp_x;
    logic comp_y;
    logic [`RLS_COMP_W-1:0] comp_word;
    logic cplx;
    logic [`RLS_IRQ_W-1:0] latch;
    logic [`RLS_IRQ_W-1:0] mptr;
    logic [`RLS_CNT_W-1:0] cnt;
    logic expired;
    logic suppress;
    logic restore;
  } rls_state_t;

endpackage : rls_pkg

// file: verilog/rls_stack.sv
// Hardware stack with a registered top-of-stack output.
`timescale 1ns/100ps

module rls_stack #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 6
) (
  // Clock and reset.
  input wire logic clk_in,
  input wire logic sys_rst_in,
  // Stack operations.
  input wire logic push_in,
  input wire logic pop_in,
  input wire logic [WIDTH-1:0] push_data_in,
  // Stack view.
  output logic [WIDTH-1:0] top_out,
  output logic empty_out,
  output logic full_out
);

  localparam int PW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] sp_r;
  logic [PW-1:0] sp_nxt;
  logic [WIDTH-1:0] top_r;
  logic [WIDTH-1:0] top_nxt;
  logic do_push;
  logic do_pop;

  // A push on a full stack and a pop on an empty one are dropped so the pointer never wraps.
  assign do_push = push_in && (sp_r != PW'(DEPTH));
  assign do_pop = pop_in && (sp_r != '0);

  // Pointer and top-of-stack next values; a push and a pop together replace the top, or push alone if the stack is empty.
  always_comb
  begin
    sp_nxt = sp_r;
    top_nxt = top_r;
    if (pop_in && push_in && (sp_r != '0))
    begin
      top_nxt = push_data_in;
    end
    else if (do_push)
    begin
      sp_nxt = sp_r + PW'(1);
      top_nxt = push_data_in;
    end
    else if (do_pop)
    begin
      sp_nxt = sp_r - PW'(1);
      top_nxt = (sp_r > PW'(1)) ? mem[sp_r - PW'(2)] : '0;
    end
  end

  // Storage array; it has no reset because the pointer marks what is valid.
  always_ff @(posedge clk_in)
  begin
    if (pop_in && push_in && (sp_r != '0))
    begin
      mem[sp_r - PW'(1)] <= push_data_in;
    end
    else if (do_push)
    begin
      mem[sp_r] <= push_data_in;
    end
  end

  // Pointer and top register.
  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in)
    begin
      sp_r <= '0;
      top_r <= '0;
    end
    else
    begin
      sp_r <= sp_nxt;
      top_r <= top_nxt;
    end
  end

  assign top_out = top_r;
  assign empty_out = (sp_r == '0);
  assign full_out = (sp_r == PW'(DEPTH));

endmodule : rls_stack

// file: verif/rls_imem.sv
// Program memory side model that presents one instruction per bench request.
`timescale 1ns/100ps
`include "rls_defs.svh"

module rls_imem (
  // Clock.
  input wire logic clk_in,
  // Request from the bench.
  input wire logic issue_in,
  input wire logic [`RLS_INSTR_W-1:0] word_in,
  input wire logic [`RLS_ADDR_W-1:0] pc_in,
  // Instruction stream towards the sequencer.
  output logic instr_valid_out,
  output logic [`RLS_INSTR_W-1:0] instr_out,
  output logic [`RLS_ADDR_W-1:0] instr_pc_out
);
  logic bad_else;

  // Well-formed code never pairs an else clause with an omitted condition.
  assign bad_else = word_in[`RLS_E_BIT] && (word_in[`RLS_CONDITION_FIELD_HI:`RLS_CONDITION_FIELD_LO] == `RLS_CONDITION_FIELD_TRUE)
    && (word_in[`RLS_GRP_HI:`RLS_GRP_LO] == `RLS_GRP_RET);

  // Known values at time zero so the first sampled cycle is not unknown.
  initial
  begin
    instr_valid_out = 1'b0;
    instr_out = 48'h000000000000;
    instr_pc_out = 24'h000000;
  end

  // Idle lines flip every cycle, so a stale opcode never passes for a fresh one.
  always @(posedge clk_in)
  begin
    instr_valid_out <= issue_in && !bad_else;
    instr_out <= issue_in ? word_in : ~instr_out;
    instr_pc_out <= issue_in ? pc_in : ~instr_pc_out;
  end
endmodule : rls_imem

// file: verif/tb.sv
// Self-checking testbench of the return and loop sequencer.
`timescale 1ns/100ps
`include "rls_defs.svh"

module tb;
  logic clk_in = 1'b0;
  logic rst = 1'b1;
  logic issue = 1'b0;
  logic [47:0] word = 48'h000000000000;
  logic [23:0] ipc = 24'h000000;
  logic vld;
  logic [47:0] instr;
  logic [23:0] pc;
  logic condition_field_x = 1'b0, condition_field_y = 1'b0, simd = 1'b0, abs_e = 1'b0;
  logic [31:0] ureg = 32'h00000000;
  logic call_push = 1'b0, loop_dec = 1'b0, loop_exit = 1'b0;
  logic [23:0] call_addr = 24'h000000;
  logic [31:0] lset = 32'h00000000, mset = 32'h00000000;
  logic take, dly, spop, xen, yen, cplx, loop_count_expired;
  logic [23:0] baddr, ptop;
  logic [22:0] cw;
  logic [31:0] lat, mptr;
  logic [15:0] cnt;
  logic [28:0] lend;
  int fail_count = 0;
  int n_compared = 0;

  // The clock toggles every half period of 2 ns.
  always #2 clk_in = ~clk_in;

  rls_imem mem_u (.clk_in(clk_in), .issue_in(issue), .word_in(word), .pc_in(ipc),
    .instr_valid_out(vld), .instr_out(instr), .instr_pc_out(pc));

  rls_sequencer dut_u (.clk_in(clk_in), .sys_rst_in(rst), .instr_valid_in(vld), .instr_in(instr),
    .instr_pc_in(pc), .condition_field_x_in(condition_field_x), .condition_field_y_in(condition_field_y), .simd_mode_in(simd),
    .abs_end_addr_in(abs_e), .ureg_data_in(ureg), .call_push_in(call_push), .call_addr_in(call_addr),
    .loop_dec_in(loop_dec), .loop_exit_in(loop_exit), .irq_latch_set_in(lset),
    .irq_mask_ptr_set_in(mset), .branch_take_out(take), .branch_addr_out(baddr),
    .branch_delayed_out(dly), .status_pop_out(spop), .compute_x_en_out(xen), .compute_y_en_out(yen),
    .compute_word_out(cw), .compute_cplx_regs_out(cplx), .irq_latch_out(lat),
    .irq_mask_pointer_out(mptr), .current_loop_count_out(cnt), .loop_count_expired_out(loop_count_expired),
    .pc_stack_top_out(ptop), .loop_end_top_out(lend));

  // Return opcode: kind, condition, delay, else, reentry and compute fields.
  function automatic logic [47:0] ret_w(input logic k, input logic [4:0] c, input logic j,
    input logic e, input logic lr, input logic [22:0] cp);
    return {`RLS_TOP_VAL, `RLS_GRP_RET, k, 2'h0, c, 6'h00, j, e, lr, 1'h0, cp};
  endfunction : ret_w

  // Counter loop opcode: count source, immediate count and end field.
  function automatic logic [47:0] loop_w(input logic s, input logic [15:0] n, input logic [23:0] r);
    return {`RLS_TOP_VAL, `RLS_GRP_LOOP, s, n, r};
  endfunction : loop_w

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("unexpected %s: expected %h, seen %h", name, exp, seen);
    end
  endtask : chk

  // One instruction; element conditions are levels during the executing cycle.
  task automatic ex(input logic [47:0] w, input logic [23:0] a, input logic cx, input logic cy);
    @(posedge clk_in);
    issue <= 1'b1;
    word <= w;
    ipc <= a;
    @(posedge clk_in);
    issue <= 1'b0;
    condition_field_x <= cx;
    condition_field_y <= cy;
    @(posedge clk_in);
    #1;
  endtask : ex

  // One cycle of sequencer events; outputs are looked at right after the sampling edge.
  task automatic ev(input logic d, input logic x, input logic p, input logic [23:0] a,
    input logic [31:0] ls, input logic [31:0] ms);
    @(posedge clk_in);
    loop_dec <= d;
    loop_exit <= x;
    call_push <= p;
    call_addr <= a;
    lset <= ls;
    mset <= ms;
    @(posedge clk_in);
    loop_dec <= 1'b0;
    loop_exit <= 1'b0;
    call_push <= 1'b0;
    lset <= 32'h00000000;
    mset <= 32'h00000000;
    #1;
  endtask : ev

  task automatic report_and_stop;
    if (fail_count == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : report_and_stop

  // The whole run needs well under a thousand cycles.
  initial
  begin
    repeat (3000) @(posedge clk_in);
    fail_count++;
    report_and_stop();
  end

  initial
  begin
    repeat (8) @(posedge clk_in);
    rst <= 1'b0;
    #1;
    chk("take", take, 32'h0);
    chk("cnt", cnt, 32'h0);
    // Immediate count with relative end, then register count with absolute end.
    ex(loop_w(1'b0, 16'h0002, 24'h000010), 24'h000100, 1'b0, 1'b0);
    chk("cnt", cnt, 32'h2);
    chk("ptop", ptop, 32'h101);
    chk("lend", lend, {3'h0, 24'h000110, `RLS_TERM_LCE});
    @(posedge clk_in);
    abs_e <= 1'b1;
    ureg <= 32'h00010005;
    ex(loop_w(1'b1, 16'hffff, 24'h000300), 24'h000200, 1'b0, 1'b0);
    chk("cnt", cnt, 32'h5);
    chk("lend", lend, {3'h0, 24'h000300, `RLS_TERM_LCE});
    ev(1'b1, 1'b0, 1'b0, 24'h0, 32'h0, 32'h0);
    chk("cnt", cnt, 32'h4);
    // Reentry return near loop end: the next decrement event is swallowed.
    ex(ret_w(1'b0, `RLS_CONDITION_FIELD_TRUE, 1'b0, 1'b0, 1'b1, `RLS_COMP_NOP), 24'h000210, 1'b0, 1'b0);
    chk("take", take, 32'h1);
    chk("baddr", baddr, 32'h201);
    chk("spop", spop, 32'h0);
    chk("dly", dly, 32'h0);
    chk("ptop", ptop, 32'h101);
    ev(1'b1, 1'b0, 1'b0, 24'h0, 32'h0, 32'h0);
    chk("cnt", cnt, 32'h4);
    ev(1'b1, 1'b0, 1'b0, 24'h0, 32'h0, 32'h0);
    chk("cnt", cnt, 32'h3);
    // Inner loop ends; the outer count comes back, then runs down to zero.
    ev(1'b0, 1'b1, 1'b0, 24'h0, 32'h0, 32'h0);
    @(posedge clk_in);
    #1;
    chk("cnt", cnt, 32'h2);
    ev(1'b1, 1'b0, 1'b0, 24'h0, 32'h0, 32'h0);
    ev(1'b1, 1'b0, 1'b0, 24'h0, 32'h0, 32'h0);
    chk("cnt", cnt, 32'h0);
    chk("lce", loop_count_expired, 32'h1);
    // Delayed conditional subroutine return.
    ev(1'b0, 1'b0, 1'b1, 24'h000abc, 32'h0, 32'h0);
    ex(ret_w(1'b0, 5'h02, 1'b1, 1'b0, 1'b0, `RLS_COMP_NOP), 24'h000400, 1'b1, 1'b0);
    chk("take", take, 32'h1);
    chk("baddr", baddr, 32'habc);
    chk("dly", dly, 32'h1);
    chk("lat", lat, 32'h0);
    // False condition: else compute runs, plain compute does not, no return.
    ex(ret_w(1'b0, 5'h02, 1'b0, 1'b1, 1'b0, 23'h012345), 24'h000401, 1'b0, 1'b0);
    chk("take", take, 32'h0);
    chk("xen", xen, 32'h1);
    chk("cw", cw, 32'h12345);
    ex(ret_w(1'b0, 5'h02, 1'b0, 1'b0, 1'b0, 23'h012345), 24'h000402, 1'b0, 1'b0);
    chk("xen", xen, 32'h0);
    // Interrupt return of a status-pushing source; the reentry bit has no effect.
    ev(1'b0, 1'b0, 1'b1, 24'h0000aa, 32'h00000008, 32'h00000008);
    chk("lat", lat, 32'h8);
    ex(ret_w(1'b1, `RLS_CONDITION_FIELD_TRUE, 1'b0, 1'b0, 1'b1, 23'h000077), 24'h000500, 1'b0, 1'b0);
    chk("baddr", baddr, 32'haa);
    chk("spop", spop, 32'h1);
    chk("lat", lat, 32'h0);
    chk("mptr", mptr, 32'h0);
    chk("xen", xen, 32'h1);
    chk("cw", cw, 32'h77);
    // A source that pushed no status pops none.
    ev(1'b0, 1'b0, 1'b1, 24'h0000bb, 32'h00000001, 32'h00000001);
    ex(ret_w(1'b1, `RLS_CONDITION_FIELD_TRUE, 1'b0, 1'b0, 1'b0, `RLS_COMP_NOP), 24'h000501, 1'b0, 1'b0);
    chk("spop", spop, 32'h0);
    chk("mptr", mptr, 32'h0);
    // Dual mode with the two elements disagreeing, then both true.
    ev(1'b0, 1'b0, 1'b1, 24'h000055, 32'h0, 32'h0);
    @(posedge clk_in);
    simd <= 1'b1;
    ex(ret_w(1'b0, 5'h02, 1'b0, 1'b0, 1'b0, 23'h000033), 24'h000600, 1'b1, 1'b0);
    chk("take", take, 32'h0);
    chk("xen yen", {xen, yen}, 32'h2);
    chk("cplx", cplx, 32'h1);
    ex(ret_w(1'b0, 5'h02, 1'b0, 1'b1, 1'b0, 23'h000033), 24'h000601, 1'b1, 1'b0);
    chk("xen yen", {xen, yen}, 32'h1);
    ex(ret_w(1'b0, 5'h02, 1'b0, 1'b0, 1'b0, `RLS_COMP_NOP), 24'h000602, 1'b1, 1'b1);
    chk("take", take, 32'h1);
    chk("baddr", baddr, 32'h55);
    // Wrong group code is ignored.
    ex({`RLS_TOP_VAL, 4'h4, 41'h00000000000}, 24'h000603, 1'b1, 1'b1);
    chk("take", take, 32'h0);
    report_and_stop();
  end
endmodule : tb
